// *** inc/line_assist_pkg.sv ***
// Package: register map, field positions and carrier types for the line assist
package line_assist_pkg;
   // Register byte offsets (one aligned word each)
   localparam logic [7:0] OFS_DATA_LINE   = 8'h00;
   localparam logic [7:0] OFS_CLOCK_LINE  = 8'h04;
   localparam logic [7:0] OFS_CONTROL     = 8'h08;
   localparam logic [7:0] OFS_FALL_STAT   = 8'h0c;
   localparam logic [7:0] OFS_RISE_STAT   = 8'h10;
   localparam logic [7:0] OFS_SAMPLED     = 8'h14;
   localparam logic [7:0] OFS_EDGE_STAT   = 8'h18;
   // Control field positions
   localparam int CTL_ON_BIT   = 0;
   localparam int CTL_HOLD_BIT = 1;
   localparam int CTL_COND_BIT = 2;
   localparam int CTL_FLAG_BIT = 3;
   // Line reset value, bus encodings and address alignment
   localparam logic       LINE_RESET = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam int         ADDR_LSB      = 2;

   // Registered AHB address phase
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } ahb_phase_s;

   // Software visible and internal state
   typedef struct packed {
      logic data_level;     // Driven level on data pad
      logic clock_level;    // Driven level on clock pad
      logic assist_on;
      logic hold_enable;
      logic cond_hold_enable;
      logic hold_active_flag;
      logic fall_condition_flag;
      logic rise_condition_flag;
      logic sampled_data_bit;
      logic new_sample_flag;
   } regs_s;
endpackage

// *** design/line_sync.sv ***
// Two-flop synchroniser for the two pad inputs
`timescale 1ns/100ps
module line_sync
   import line_assist_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [1:0] async_in,
   output logic      [1:0] sync_out
);
   // First stage, read only by the second stage
   logic [1:0] meta;

   // Idle lines are high, so reset to high avoids false edges
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         meta     <= {2{LINE_RESET}};
         sync_out <= {2{LINE_RESET}};
      end else begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// *** design/sync_serial_line_assist.sv ***
// Two-wire line assist: open-drain pad control, condition detect, stretching, sampling
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/100ps
module sync_serial_line_assist
   import line_assist_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // Port B bit four (clock line)
   input  wire logic        port_b_bit_four_in,
   output logic             port_b_bit_four_out,
   output logic             port_b_bit_four_oe,
   // Port B bit five (data line)
   input  wire logic        port_b_bit_five_in,
   output logic             port_b_bit_five_out,
   output logic             port_b_bit_five_oe,
   // One-cycle pulse outputs toward the interrupt manager
   output logic             fall_condition_irq,
   output logic             rise_condition_irq,
   // Tells port B its pins are taken over
   output logic             port_b_override
);
   // Whole module state
   typedef struct packed {
      ahb_phase_s phase;     // Pending data phase
      regs_s      regs;      // Register contents
      logic       clk_prev;  // Last synchronised clock line
      logic       dat_prev;  // Last synchronised data line
      logic       fall_irq;
      logic       rise_irq;
      logic [31:0] rdata;
   } state_s;

   state_s st;
   state_s next_st;
   logic [1:0] pads_sync;    // {data, clock} after synchroniser
   logic       clock_line;   // Wired clock level
   logic       data_line;    // Wired data level
   logic       clk_rise;
   logic       clk_fall;
   logic       dat_rise;
   logic       dat_fall;
   logic       addr_take;
   logic       wr_fall;
   logic       wr_rise;
   logic       wr_sampled;
   logic       rd_sampled;
   logic       hold_start;
   logic       drive_clock_low;
   logic       drive_data_low;

   // Pads pass two flops before any logic looks at them
   line_sync u_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .async_in ({port_b_bit_five_in, port_b_bit_four_in}),
      .sync_out (pads_sync)
   );

   assign clock_line = pads_sync[0];
   assign data_line  = pads_sync[1];

   // Edge detect on synchronised lines
   assign clk_rise = clock_line & ~st.clk_prev;
   assign clk_fall = ~clock_line & st.clk_prev;
   assign dat_rise = data_line & ~st.dat_prev;
   assign dat_fall = ~data_line & st.dat_prev;

   // Zero-wait slave: address phase taken when selected and bus ready
   assign addr_take  = hsel & hready & (htrans == HTRANS_NONSEQ);
   assign wr_fall    = st.phase.valid & st.phase.write & (st.phase.addr == OFS_FALL_STAT);
   assign wr_rise    = st.phase.valid & st.phase.write & (st.phase.addr == OFS_RISE_STAT);
   assign wr_sampled = st.phase.valid & st.phase.write & (st.phase.addr == OFS_SAMPLED);
   assign rd_sampled = addr_take & ~hwrite & (haddr[7:0] == OFS_SAMPLED);

   // A hold begins on a clock fall, unconditional or after the fall condition
   assign hold_start = st.regs.assist_on & clk_fall &
                       (st.regs.hold_enable |
                        (st.regs.cond_hold_enable & st.regs.fall_condition_flag));

   // Open drain: only ever drive low, never high
   assign drive_clock_low = st.regs.assist_on &
                            (~st.regs.clock_level | st.regs.hold_active_flag);
   assign drive_data_low  = st.regs.assist_on & ~st.regs.data_level;

   assign port_b_bit_four_out = 1'b0;
   assign port_b_bit_four_oe  = drive_clock_low;
   assign port_b_bit_five_out = 1'b0;
   assign port_b_bit_five_oe  = drive_data_low;
   assign port_b_override     = st.regs.assist_on;

   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign hrdata             = st.rdata;
   assign fall_condition_irq = st.fall_irq;
   assign rise_condition_irq = st.rise_irq;

   // Next state: bus phase, register writes, detection and reads
   always_comb begin
      next_st = st;
      next_st.clk_prev = clock_line;
      next_st.dat_prev = data_line;
      next_st.fall_irq = 1'b0;
      next_st.rise_irq = 1'b0;

      // Capture address phase
      next_st.phase.valid = addr_take;
      next_st.phase.write = hwrite;
      next_st.phase.addr  = {haddr[7:ADDR_LSB], 2'h0};

      // Data-phase writes
      if (st.phase.valid && st.phase.write) begin
         case (st.phase.addr)
            OFS_DATA_LINE: begin
               next_st.regs.data_level = hwdata[0];
            end
            OFS_CLOCK_LINE: begin
               next_st.regs.clock_level = hwdata[0];
            end
            OFS_CONTROL: begin
               next_st.regs.assist_on        = hwdata[CTL_ON_BIT];
               next_st.regs.hold_enable      = hwdata[CTL_HOLD_BIT];
               next_st.regs.cond_hold_enable = hwdata[CTL_COND_BIT];
            end
            default: begin
               // Status clears handled below, others ignored
            end
         endcase
      end

      // Write clears come first so a same-cycle detection wins
      if (wr_fall) begin
         next_st.regs.fall_condition_flag = 1'b0;
      end
      if (wr_rise) begin
         next_st.regs.rise_condition_flag = 1'b0;
      end
      if (wr_sampled) begin
         next_st.regs.hold_active_flag = 1'b0;
      end

      // Conditions seen the same way in either direction
      if (st.regs.assist_on && clock_line && st.clk_prev) begin
         if (dat_fall) begin
            next_st.regs.fall_condition_flag = 1'b1;
            next_st.fall_irq = 1'b1;
         end
         if (dat_rise) begin
            next_st.regs.rise_condition_flag = 1'b1;
            next_st.rise_irq = 1'b1;
         end
      end

      // Stretch on falling clock; set beats release
      if (hold_start) begin
         next_st.regs.hold_active_flag = 1'b1;
      end

      // Sample data on clock rise; read clears, set wins
      if (rd_sampled) begin
         next_st.regs.new_sample_flag = 1'b0;
      end
      if (st.regs.assist_on && clk_rise) begin
         next_st.regs.sampled_data_bit = data_line;
         next_st.regs.new_sample_flag  = 1'b1;
      end

      // Disabling the block drops any hold so the clock is never left stuck
      if (!next_st.regs.assist_on) begin
         next_st.regs.hold_active_flag = 1'b0;
      end

      // Read data for the next data phase; unused bits zero
      next_st.rdata = 32'h0;
      if (addr_take && !hwrite) begin
         case ({haddr[7:ADDR_LSB], 2'h0})
            OFS_DATA_LINE:  next_st.rdata[0] = data_line;
            OFS_CLOCK_LINE: next_st.rdata[0] = clock_line;
            OFS_CONTROL: begin
               next_st.rdata[CTL_ON_BIT]   = st.regs.assist_on;
               next_st.rdata[CTL_HOLD_BIT] = st.regs.hold_enable;
               next_st.rdata[CTL_COND_BIT] = st.regs.cond_hold_enable;
               next_st.rdata[CTL_FLAG_BIT] = st.regs.hold_active_flag;
            end
            OFS_FALL_STAT:  next_st.rdata[0] = st.regs.fall_condition_flag;
            OFS_RISE_STAT:  next_st.rdata[0] = st.regs.rise_condition_flag;
            OFS_SAMPLED:    next_st.rdata[0] = st.regs.sampled_data_bit;
            OFS_EDGE_STAT:  next_st.rdata[0] = st.regs.new_sample_flag;
            default:        next_st.rdata = 32'h0;
         endcase
      end
   end

   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st                  <= '0;
         st.regs.data_level  <= LINE_RESET;
         st.regs.clock_level <= LINE_RESET;
         st.clk_prev         <= LINE_RESET;
         st.dat_prev         <= LINE_RESET;
      end else begin
         st <= next_st;
      end
   end

   // Assertions
   property p_fall_flag;
      @(posedge ref_clk) disable iff (rst)
      (st.regs.assist_on && clock_line && st.clk_prev && dat_fall)
         |=> (st.regs.fall_condition_flag && fall_condition_irq);
   endproperty
   a_fall_flag: assert property (p_fall_flag) else $error("fall condition missed");

   property p_rise_flag;
      @(posedge ref_clk) disable iff (rst)
      (st.regs.assist_on && clock_line && st.clk_prev && dat_rise)
         |=> (st.regs.rise_condition_flag && rise_condition_irq);
   endproperty
   a_rise_flag: assert property (p_rise_flag) else $error("rise condition missed");

   property p_fall_clear;
      @(posedge ref_clk) disable iff (rst)
      (wr_fall && !(st.regs.assist_on && clock_line && st.clk_prev && dat_fall))
         |=> !st.regs.fall_condition_flag;
   endproperty
   a_fall_clear: assert property (p_fall_clear) else $error("fall flag not cleared");

   property p_rise_clear;
      @(posedge ref_clk) disable iff (rst)
      (wr_rise && !(st.regs.assist_on && clock_line && st.clk_prev && dat_rise))
         |=> !st.regs.rise_condition_flag;
   endproperty
   a_rise_clear: assert property (p_rise_clear) else $error("rise flag not cleared");

   property p_hold;
      @(posedge ref_clk) disable iff (rst)
      (st.regs.assist_on && st.regs.hold_enable && clk_fall)
         |=> (st.regs.hold_active_flag && port_b_bit_four_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("clock not held");

   property p_cond_hold;
      @(posedge ref_clk) disable iff (rst)
      (st.regs.assist_on && !st.regs.hold_enable && clk_fall && !st.regs.hold_active_flag
       && st.regs.cond_hold_enable && !st.regs.fall_condition_flag) |=> !st.regs.hold_active_flag;
   endproperty
   a_cond_hold: assert property (p_cond_hold) else $error("hold without condition");

   property p_release;
      @(posedge ref_clk) disable iff (rst)
      (wr_sampled && !hold_start) |=> !st.regs.hold_active_flag;
   endproperty
   a_release: assert property (p_release) else $error("hold not released");

   property p_sample;
      @(posedge ref_clk) disable iff (rst)
      (st.regs.assist_on && clk_rise)
         |=> (st.regs.sampled_data_bit == $past(data_line)) && st.regs.new_sample_flag;
   endproperty
   a_sample: assert property (p_sample) else $error("sample wrong");

   property p_sample_read;
      @(posedge ref_clk) disable iff (rst)
      (rd_sampled && !(st.regs.assist_on && clk_rise)) |=> !st.regs.new_sample_flag;
   endproperty
   a_sample_read: assert property (p_sample_read) else $error("new flag not cleared");

   property p_open_drain;
      @(posedge ref_clk) disable iff (rst)
      !st.regs.assist_on |-> !(port_b_bit_four_oe || port_b_bit_five_oe);
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("pad driven while off");

   c_fall: cover property (@(posedge ref_clk) disable iff (rst) fall_condition_irq);
   c_rise: cover property (@(posedge ref_clk) disable iff (rst) rise_condition_irq);
   c_hold: cover property (@(posedge ref_clk) disable iff (rst)
                           st.regs.hold_active_flag ##1 !st.regs.hold_active_flag);
   c_samp: cover property (@(posedge ref_clk) disable iff (rst) clk_rise && st.regs.assist_on);
endmodule

// *** tb/line_partner.sv ***
// Remote two-wire party: open-drain pulls on both lines, pull-ups
`timescale 1ns/100ps
module line_partner (
   input  wire logic clk_oe,
   input  wire logic data_oe,
   output logic      clk_wire,
   output logic      data_wire
);
   logic clk_low  = 1'b0; // Partner pulls clock low
   logic data_low = 1'b0; // Partner pulls data low
   // Wired-AND; a released line floats up to the pull-up
   assign clk_wire  = ~(clk_oe | clk_low);
   assign data_wire = ~(data_oe | data_low);
   // Data change while clock stands high
   task automatic data_to(input logic b);
      data_low <= ~b;
      #400;
   endtask
   // One 800 ns bit; data moves only while clock is low
   task automatic send_bit(input logic b);
      clk_low <= 1'b1;
      #200 data_low <= ~b;
      #200 clk_low <= 1'b0;
      // Honour stretching: wait for the line to rise
      wait (clk_wire === 1'b1);
      #400;
   endtask
   // Falling edge only; the line may then stay held
   task automatic clk_fall();
      clk_low <= 1'b1;
      #400 clk_low <= 1'b0;
      #400;
   endtask
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench: bus tasks, link partner and scenarios
`timescale 1ns/100ps
module tb_top;
   import line_assist_pkg::*;
   logic        ref_clk = 1'b0; // 10 MHz
   logic        rst     = 1'b1; // Held 20 cycles
   logic        hsel;           // Bus select, driven by the tasks
   logic [31:0] haddr;          // Bus address
   logic [1:0]  htrans;         // Transfer type
   logic        hwrite;         // Write strobe
   logic [2:0]  hsize;          // Transfer size, whole words only
   logic [31:0] hwdata;         // Write data
   logic        hrdy, hresp, clk_oe, data_oe, clk_w, data_w, over;
   logic        clk_out, data_out; // Pad output levels, must stay low
   logic        fall_irq, rise_irq;
   logic [31:0] hrdata, rd;
   int          errors = 0; // Mismatches
   int          checks = 0; // Comparisons
   int          falls = 0;  // Fall request pulses
   int          rises = 0;  // Rise request pulses
   // Half period 50 ns
   always #50 ref_clk = ~ref_clk;
   sync_serial_line_assist i_sync_serial_line_assist (
      .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
      .hrdata(hrdata), .port_b_bit_four_in(clk_w),
      .port_b_bit_four_out(clk_out), .port_b_bit_four_oe(clk_oe),
      .port_b_bit_five_in(data_w), .port_b_bit_five_out(data_out),
      .port_b_bit_five_oe(data_oe), .fall_condition_irq(fall_irq),
      .rise_condition_irq(rise_irq), .port_b_override(over)
   );
   line_partner i_line_partner (
      .clk_oe(clk_oe), .data_oe(data_oe), .clk_wire(clk_w), .data_wire(data_w)
   );
   // Pulses, so each event adds exactly one
   always @(posedge ref_clk) begin
      falls <= falls + int'(fall_irq === 1'b1);
      rises <= rises + int'(rise_irq === 1'b1);
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One single word transfer; waits on hready, no fixed latency
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      hsize  <= HSIZE_WORD;
      do @(posedge ref_clk); while (hrdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(what, rd, exp);
   endtask
   // Pad edges need the synchroniser's few cycles
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic close_out();
      $display("Counts: checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Tests take under 100 us; 2 ms means a hang
   initial begin
      #2_000_000;
      errors++;
      close_out();
   end
   initial begin
      // Bus starts idle while reset is held
      hsel   <= 1'b0;
      haddr  <= 32'h0;
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hsize  <= HSIZE_WORD;
      hwdata <= 32'h0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values, unmapped word, read-only bit
      rc("data", OFS_DATA_LINE, 32'h1);
      rc("clock", OFS_CLOCK_LINE, 32'h1);
      rc("ctl", OFS_CONTROL, 32'h0);
      rc("fall", OFS_FALL_STAT, 32'h0);
      rc("rise", OFS_RISE_STAT, 32'h0);
      rc("smp", OFS_SAMPLED, 32'h0);
      rc("edge", OFS_EDGE_STAT, 32'h0);
      wr(8'h1c, 32'hff);
      rc("unmapped", 8'h1c, 32'h0);
      chk("hresp", {31'h0, hresp}, 32'h0);
      chk("over", {31'h0, over}, 32'h0);
      wr(OFS_CONTROL, 32'h0f);
      rc("ctl_ro", OFS_CONTROL, 32'h7);
      wr(OFS_CONTROL, 32'h1);
      $display("Test reset done");
      // Device as sender: its own data edges under a high clock
      idle(2);
      chk("over", {31'h0, over}, 32'h1);
      wr(OFS_DATA_LINE, 32'h0);
      idle(4);
      chk("oe", {30'h0, clk_oe, data_oe}, 32'h1);
      chk("pad_out", {30'h0, clk_out, data_out}, 32'h0);
      rc("data0", OFS_DATA_LINE, 32'h0);
      rc("fall_tx", OFS_FALL_STAT, 32'h1);
      chk("fall_irq", falls, 32'h1);
      wr(OFS_DATA_LINE, 32'h1);
      idle(4);
      rc("rise_tx", OFS_RISE_STAT, 32'h1);
      chk("rise_irq", rises, 32'h1);
      wr(OFS_FALL_STAT, 32'h0);
      wr(OFS_RISE_STAT, 32'h0);
      rc("fall_clr", OFS_FALL_STAT, 32'h0);
      rc("rise_clr", OFS_RISE_STAT, 32'h0);
      $display("Test sender done");
      // Far side pulls data low over a written 1
      i_line_partner.data_to(1'b0);
      rc("wired", OFS_DATA_LINE, 32'h0);
      rc("fall_rx", OFS_FALL_STAT, 32'h1);
      chk("fall_irq", falls, 32'h2);
      i_line_partner.data_to(1'b1);
      rc("rise_rx", OFS_RISE_STAT, 32'h1);
      chk("rise_irq", rises, 32'h2);
      $display("Test receiver done");
      // Clock pad driven low then released: one rising edge
      wr(OFS_CLOCK_LINE, 32'h0);
      idle(4);
      chk("oe", {30'h0, clk_oe, data_oe}, 32'h2);
      rc("clock0", OFS_CLOCK_LINE, 32'h0);
      wr(OFS_CLOCK_LINE, 32'h1);
      idle(4);
      rc("edge1", OFS_EDGE_STAT, 32'h1);
      rc("smp1", OFS_SAMPLED, 32'h1);
      rc("edge0", OFS_EDGE_STAT, 32'h0);
      i_line_partner.send_bit(1'b0);
      rc("smp0", OFS_SAMPLED, 32'h0);
      i_line_partner.send_bit(1'b1);
      rc("edge", OFS_EDGE_STAT, 32'h1);
      rc("smp", OFS_SAMPLED, 32'h1);
      $display("Test sampling done");
      // Unconditional hold, released by a sampled-data write
      wr(OFS_CONTROL, 32'h3);
      i_line_partner.clk_fall();
      chk("held", {31'h0, clk_w}, 32'h0);
      rc("ctl_h", OFS_CONTROL, 32'h0b);
      wr(OFS_SAMPLED, 32'h0);
      idle(4);
      chk("free", {31'h0, clk_w}, 32'h1);
      rc("ctl_f", OFS_CONTROL, 32'h3);
      // Conditional hold only once the fall flag is set
      wr(OFS_CONTROL, 32'h5);
      wr(OFS_FALL_STAT, 32'h0);
      i_line_partner.send_bit(1'b1);
      rc("ctl_nc", OFS_CONTROL, 32'h5);
      i_line_partner.data_to(1'b0);
      i_line_partner.clk_fall();
      rc("ctl_c", OFS_CONTROL, 32'h0d);
      wr(OFS_SAMPLED, 32'h0);
      idle(4);
      rc("ctl_cf", OFS_CONTROL, 32'h5);
      $display("Test hold done");
      // Disabled: no condition is flagged
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_FALL_STAT, 32'h0);
      i_line_partner.data_to(1'b1);
      i_line_partner.data_to(1'b0);
      rc("fall_off", OFS_FALL_STAT, 32'h0);
      $display("Test disabled done");
      close_out();
   end
endmodule
